// [efs_breaker_model.sv]
`default_nettype none
module efs_breaker_model (
  // Clock
  input wire logic aclk,
  // Breaker coil and contacts
  input wire logic breaker_trip,
  input wire logic [15:0] open_delay,
  output logic breaker_open_status
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // Contacts open only after the coil has been held for the set delay; they reclose when it drops
  always @(posedge aclk) begin
    if (breaker_trip !== 1'b1) begin
      cnt <= 0;
      breaker_open_status <= 1'b0;
    end else begin
      if (cnt < open_delay) cnt <= cnt + 1;
      breaker_open_status <= (cnt >= open_delay);
    end
  end
endmodule
`default_nettype wire

// [efs_interval_timer.sv]
`default_nettype none
module efs_interval_timer (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic run,
  input wire logic tick,
  input wire logic [15:0] limit,
  // Result
  output logic done
);
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;

  assign done = run && (cnt_reg >= limit);
  // Dropping run clears the count, so only unbroken intervals reach the limit
  assign cnt_next = !run ? 16'h0000 : (tick && !done) ? cnt_reg + 16'h0001 : cnt_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule
`default_nettype wire

// [efs_pkg.sv]
// Overview of operation
// - High condition: control signal above high threshold, default 1.00, step 0.01.
// - Low condition: field current at or below low threshold, default 0.10.
// - Open-field qualifying delay, default 3.000 s, set in 0.005 s steps.
// - Monitoring enabled and both conditions for whole delay: rectifier trip, excitation stop.
// - Alarm when power transistor temperature exceeds level, default 100, integer steps.
// - Over-temperature supervision always active; no enable can switch it off.
// - Internal breaker tripping enable, default off; off means no trip sequencing.
// - Enabled, machine circuit open, breaker OFF: run current down, then open breaker.
// - Inverter-mode run-down time, default 1.0 s, 0.1 s steps, before breaker opens.
// - After breaker trip, event if open status not seen within 0.5 s default.
// - Open-loop source selected: ramp control signal up or down, default 0.02 p.u./s.
`default_nettype none
package efs_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int T_BASE_NS = 5_000_000;
  localparam int CYC_BASE = T_BASE_NS / CLK_PERIOD_NS;
  localparam int T_BASE_MS = 5;
  localparam int T_RAMP_MS = 10;
  localparam int T_COARSE_MS = 100;
  localparam logic [4:0] TICKS_RAMP = 5'(T_RAMP_MS / T_BASE_MS);
  localparam logic [4:0] TICKS_COARSE = 5'(T_COARSE_MS / T_BASE_MS);

  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_OF_HIGH = 8'h04;
  localparam logic [7:0] OFF_OF_LOW = 8'h08;
  localparam logic [7:0] OFF_OF_DELAY = 8'h0C;
  localparam logic [7:0] OFF_TEMP_LVL = 8'h10;
  localparam logic [7:0] OFF_INV_TIME = 8'h14;
  localparam logic [7:0] OFF_TRIP_SUP = 8'h18;
  localparam logic [7:0] OFF_RAMP_RATE = 8'h1C;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_MASK = 8'h24;
  localparam logic [7:0] OFF_LIVE = 8'h28;
  localparam logic [7:0] OFF_RAMP_VAL = 8'h2C;

  // Thresholds in 0.01 units, delays in 5 ms, breaker times in 100 ms, rate in 0.01 p.u./s
  localparam logic [15:0] RST_OF_HIGH = 16'h0064;
  localparam logic [15:0] RST_OF_LOW = 16'h000A;
  localparam logic [15:0] RST_OF_DELAY = 16'h0258;
  localparam logic [7:0] RST_TEMP_LVL = 8'h64;
  localparam logic [15:0] RST_INV_TIME = 16'h000A;
  localparam logic [15:0] RST_TRIP_SUP = 16'h0005;
  localparam logic [7:0] RST_RAMP_RATE = 8'h02;
  // Ramp value in 0.0001 p.u., capped at 25.00 p.u.
  localparam logic [19:0] RAMP_MAX = 20'h3_D090;

  localparam int ST_OF_TRIP = 0;
  localparam int ST_TEMP = 1;
  localparam int ST_BRK_FAIL = 2;
  localparam int ST_BRK_OPEN = 3;
  localparam logic [3:0] RST_STATUS = 4'h0;

  typedef struct packed {
    logic [26:0] rsvd;
    logic ramp_down;
    logic ramp_up;
    logic open_loop_sel;
    logic trip_en;
    logic of_en;
  } efs_ctrl_t;
  localparam efs_ctrl_t RST_CTRL = '0;

  typedef enum logic [1:0] {BRK_IDLE, BRK_RUNDOWN, BRK_WAIT, BRK_DONE} efs_brk_t;

  typedef struct packed {
    logic [15:0] control_signal;
    logic [15:0] field_current;
    logic [7:0] temp;
  } efs_meas_t;
endpackage
`default_nettype wire

// [efs_supervisor.sv]
// Added by the designer: register access over AXI4-Lite and the address map.
`default_nettype none
module efs_supervisor #(
  parameter int CYC_BASE = efs_pkg::CYC_BASE
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output var logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output var logic wready,
  output var logic [1:0] bresp,
  output var logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output var logic arready,
  output var logic [31:0] rdata,
  output var logic [1:0] rresp,
  output var logic rvalid,
  input wire logic rready,
  // Measurements
  input wire efs_pkg::efs_meas_t meas,
  // Field breaker and machine circuit
  input wire logic breaker_off_cmd,
  input wire logic machine_circuit_open,
  input wire logic breaker_open_status,
  // Actions
  output var logic rectifier_trip,
  output var logic excitation_stop,
  output var logic excitation_rundown,
  output var logic breaker_trip,
  output var logic temp_alarm,
  output var logic [19:0] forced_control_signal,
  output var logic forced_active,
  output var logic irq
);
  efs_pkg::efs_ctrl_t ctrl_reg;
  logic [15:0] of_high_reg, of_low_reg, of_delay_reg, inv_time_reg, trip_sup_reg;
  logic [7:0] temp_lvl_reg, ramp_rate_reg;
  logic [3:0] status_reg, mask_reg, status_next;
  logic aw_free_reg, w_free_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  efs_pkg::efs_brk_t brk_reg, brk_next;
  logic [19:0] base_cnt_reg;
  logic [4:0] ramp_div_reg, coarse_div_reg;
  logic [19:0] ramp_reg, ramp_next;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  // Bus decode
  wire do_wr = !aw_free_reg && !w_free_reg && !bvalid;
  wire [31:0] wmask = merge(32'h0000_0000, wdata_reg, wstrb_reg);
  wire wr_ctrl = do_wr && (awaddr_reg == efs_pkg::OFF_CTRL);
  wire wr_high = do_wr && (awaddr_reg == efs_pkg::OFF_OF_HIGH);
  wire wr_low = do_wr && (awaddr_reg == efs_pkg::OFF_OF_LOW);
  wire wr_delay = do_wr && (awaddr_reg == efs_pkg::OFF_OF_DELAY);
  wire wr_temp = do_wr && (awaddr_reg == efs_pkg::OFF_TEMP_LVL);
  wire wr_inv = do_wr && (awaddr_reg == efs_pkg::OFF_INV_TIME);
  wire wr_sup = do_wr && (awaddr_reg == efs_pkg::OFF_TRIP_SUP);
  wire wr_rate = do_wr && (awaddr_reg == efs_pkg::OFF_RAMP_RATE);
  wire wr_status = do_wr && (awaddr_reg == efs_pkg::OFF_STATUS);
  wire wr_mask = do_wr && (awaddr_reg == efs_pkg::OFF_MASK);
  wire wr_hit = wr_ctrl || wr_high || wr_low || wr_delay || wr_temp || wr_inv || wr_sup || wr_rate
                || wr_status || wr_mask;

  // Base 5 ms tick and slower enables derived from it
  wire base_tick = (base_cnt_reg == 20'(CYC_BASE - 1));
  wire ramp_tick = base_tick && (ramp_div_reg == efs_pkg::TICKS_RAMP - 5'd1);
  wire coarse_tick = base_tick && (coarse_div_reg == efs_pkg::TICKS_COARSE - 5'd1);

  // Open-field detection
  wire hi_cond = meas.control_signal > of_high_reg;
  wire lo_cond = meas.field_current <= of_low_reg;
  wire of_qual = ctrl_reg.of_en && hi_cond && lo_cond;
  wire of_done;
  efs_interval_timer u_of_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(of_qual),
    .tick(base_tick),
    .limit(of_delay_reg),
    .done(of_done)
  );
  wire of_trip_evt = of_done;

  // Temperature check has no enable term on purpose
  wire temp_hot = meas.temp > temp_lvl_reg;

  // Breaker sequencing
  wire brk_start = ctrl_reg.trip_en && machine_circuit_open && breaker_off_cmd;
  wire inv_done, sup_done;
  efs_interval_timer u_inv_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(brk_reg == efs_pkg::BRK_RUNDOWN),
    .tick(coarse_tick),
    .limit(inv_time_reg),
    .done(inv_done)
  );
  efs_interval_timer u_sup_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(brk_reg == efs_pkg::BRK_WAIT),
    .tick(coarse_tick),
    .limit(trip_sup_reg),
    .done(sup_done)
  );
  wire brk_open_evt = (brk_reg == efs_pkg::BRK_WAIT) && breaker_open_status;
  wire brk_fail_evt = (brk_reg == efs_pkg::BRK_WAIT) && !breaker_open_status && sup_done;

  always_comb begin
    brk_next = brk_reg;
    case (brk_reg)
      efs_pkg::BRK_IDLE: if (brk_start) brk_next = efs_pkg::BRK_RUNDOWN;
      efs_pkg::BRK_RUNDOWN: if (inv_done) brk_next = efs_pkg::BRK_WAIT;
      efs_pkg::BRK_WAIT: if (brk_open_evt || brk_fail_evt) brk_next = efs_pkg::BRK_DONE;
      efs_pkg::BRK_DONE: if (!breaker_off_cmd) brk_next = efs_pkg::BRK_IDLE;
      default: brk_next = efs_pkg::BRK_IDLE;
    endcase
    if (!ctrl_reg.trip_en) brk_next = efs_pkg::BRK_IDLE;
  end

  // Test ramp
  wire ramp_on = ctrl_reg.open_loop_sel && ramp_tick;
  wire [20:0] ramp_sum = {1'b0, ramp_reg} + {13'h0000, ramp_rate_reg};
  wire ramp_lo = ramp_reg < {12'h000, ramp_rate_reg};
  always_comb begin
    ramp_next = ramp_reg;
    if (ramp_on && ctrl_reg.ramp_up && !ctrl_reg.ramp_down) begin
      ramp_next = (ramp_sum > {1'b0, efs_pkg::RAMP_MAX}) ? efs_pkg::RAMP_MAX : ramp_sum[19:0];
    end else if (ramp_on && ctrl_reg.ramp_down && !ctrl_reg.ramp_up) begin
      ramp_next = ramp_lo ? 20'h0_0000 : ramp_reg - {12'h000, ramp_rate_reg};
    end
  end

  // Sticky status; a new event outranks a clear in the same cycle
  wire [3:0] events = {brk_open_evt, brk_fail_evt, temp_hot, of_trip_evt};
  assign status_next = (status_reg & ~(wr_status ? wmask[3:0] : 4'h0)) | events;

  // Read mux
  wire [31:0] live_word = {21'h0_0000, forced_active, breaker_trip,
                           excitation_rundown, rectifier_trip, brk_reg, breaker_open_status,
                           temp_hot, lo_cond, hi_cond, of_qual};
  wire [31:0] rd_word =
    (araddr == efs_pkg::OFF_CTRL) ? ctrl_reg :
    (araddr == efs_pkg::OFF_OF_HIGH) ? {16'h0000, of_high_reg} :
    (araddr == efs_pkg::OFF_OF_LOW) ? {16'h0000, of_low_reg} :
    (araddr == efs_pkg::OFF_OF_DELAY) ? {16'h0000, of_delay_reg} :
    (araddr == efs_pkg::OFF_TEMP_LVL) ? {24'h00_0000, temp_lvl_reg} :
    (araddr == efs_pkg::OFF_INV_TIME) ? {16'h0000, inv_time_reg} :
    (araddr == efs_pkg::OFF_TRIP_SUP) ? {16'h0000, trip_sup_reg} :
    (araddr == efs_pkg::OFF_RAMP_RATE) ? {24'h00_0000, ramp_rate_reg} :
    (araddr == efs_pkg::OFF_STATUS) ? {28'h000_0000, status_reg} :
    (araddr == efs_pkg::OFF_MASK) ? {28'h000_0000, mask_reg} :
    (araddr == efs_pkg::OFF_LIVE) ? live_word :
    (araddr == efs_pkg::OFF_RAMP_VAL) ? {12'h000, ramp_reg} : 32'h0000_0000;
  wire rd_hit = (araddr <= efs_pkg::OFF_RAMP_VAL) && (araddr[1:0] == 2'b00);

  // Write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_free_reg <= 1'b1;
      w_free_reg <= 1'b1;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'b00;
    end else begin
      if (awvalid && aw_free_reg) begin
        aw_free_reg <= 1'b0;
        awaddr_reg <= awaddr;
      end
      if (wvalid && w_free_reg) begin
        w_free_reg <= 1'b0;
        wdata_reg <= wdata;
        wstrb_reg <= wstrb;
      end
      if (do_wr) begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? 2'b00 : 2'b10;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
        aw_free_reg <= 1'b1;
        w_free_reg <= 1'b1;
      end
    end
  end
  assign awready = aw_free_reg;
  assign wready = w_free_reg;

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= 2'b00;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= rd_hit ? 2'b00 : 2'b10;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Settings registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= efs_pkg::RST_CTRL;
      of_high_reg <= efs_pkg::RST_OF_HIGH;
      of_low_reg <= efs_pkg::RST_OF_LOW;
      of_delay_reg <= efs_pkg::RST_OF_DELAY;
      temp_lvl_reg <= efs_pkg::RST_TEMP_LVL;
      inv_time_reg <= efs_pkg::RST_INV_TIME;
      trip_sup_reg <= efs_pkg::RST_TRIP_SUP;
      ramp_rate_reg <= efs_pkg::RST_RAMP_RATE;
      mask_reg <= 4'h0;
    end else begin
      if (wr_ctrl) ctrl_reg <= efs_pkg::efs_ctrl_t'(merge(ctrl_reg, wdata_reg, wstrb_reg) & 32'h0000_001F);
      if (wr_high) of_high_reg <= 16'(merge({16'h0000, of_high_reg}, wdata_reg, wstrb_reg));
      if (wr_low) of_low_reg <= 16'(merge({16'h0000, of_low_reg}, wdata_reg, wstrb_reg));
      if (wr_delay) of_delay_reg <= 16'(merge({16'h0000, of_delay_reg}, wdata_reg, wstrb_reg));
      if (wr_temp) temp_lvl_reg <= wstrb_reg[0] ? wdata_reg[7:0] : temp_lvl_reg;
      if (wr_inv) inv_time_reg <= 16'(merge({16'h0000, inv_time_reg}, wdata_reg, wstrb_reg));
      if (wr_sup) trip_sup_reg <= 16'(merge({16'h0000, trip_sup_reg}, wdata_reg, wstrb_reg));
      if (wr_rate) ramp_rate_reg <= wstrb_reg[0] ? wdata_reg[7:0] : ramp_rate_reg;
      if (wr_mask) mask_reg <= wstrb_reg[0] ? wdata_reg[3:0] : mask_reg;
    end
  end

  // Dividers, state, ramp and status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      base_cnt_reg <= 20'h0_0000;
      ramp_div_reg <= 5'h00;
      coarse_div_reg <= 5'h00;
      brk_reg <= efs_pkg::BRK_IDLE;
      ramp_reg <= 20'h0_0000;
      status_reg <= efs_pkg::RST_STATUS;
    end else begin
      base_cnt_reg <= base_tick ? 20'h0_0000 : base_cnt_reg + 20'h0_0001;
      if (base_tick) begin
        ramp_div_reg <= (ramp_div_reg == efs_pkg::TICKS_RAMP - 5'd1) ? 5'h00 : ramp_div_reg + 5'd1;
        coarse_div_reg <= (coarse_div_reg == efs_pkg::TICKS_COARSE - 5'd1) ? 5'h00 : coarse_div_reg + 5'd1;
      end
      brk_reg <= brk_next;
      ramp_reg <= ramp_next;
      status_reg <= status_next;
    end
  end

  // Registered outputs; an open-field trip holds until its status bit is cleared
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rectifier_trip <= 1'b0;
      excitation_stop <= 1'b0;
      excitation_rundown <= 1'b0;
      breaker_trip <= 1'b0;
      temp_alarm <= 1'b0;
      forced_control_signal <= 20'h0_0000;
      forced_active <= 1'b0;
      irq <= 1'b0;
    end else begin
      rectifier_trip <= of_trip_evt || (rectifier_trip && status_next[efs_pkg::ST_OF_TRIP]);
      excitation_stop <= of_trip_evt || (rectifier_trip && status_next[efs_pkg::ST_OF_TRIP]);
      excitation_rundown <= (brk_next != efs_pkg::BRK_IDLE);
      breaker_trip <= (brk_next == efs_pkg::BRK_WAIT) || (brk_next == efs_pkg::BRK_DONE);
      temp_alarm <= temp_hot;
      forced_control_signal <= ramp_next;
      forced_active <= ctrl_reg.open_loop_sel;
      irq <= |(status_next & mask_reg);
    end
  end

  // Checks
  logic [15:0] qual_ticks;
  always_ff @(posedge aclk) begin
    if (!aresetn || !of_qual) qual_ticks <= 16'h0000;
    else if (base_tick && qual_ticks != 16'hFFFF) qual_ticks <= qual_ticks + 16'h0001;
  end

  property p_hi_cause;
    @(posedge aclk) disable iff (!aresetn) $rose(rectifier_trip) |-> $past(meas.control_signal > of_high_reg);
  endproperty
  a_hi_cause: assert property (p_hi_cause) else $error("trip without high control signal");
  property p_lo_cause;
    @(posedge aclk) disable iff (!aresetn) $rose(rectifier_trip) |-> $past(meas.field_current <= of_low_reg);
  endproperty
  a_lo_cause: assert property (p_lo_cause) else $error("trip without low field current");
  property p_delay_met;
    @(posedge aclk) disable iff (!aresetn) $rose(rectifier_trip) |-> $past(qual_ticks) >= $past(of_delay_reg);
  endproperty
  a_delay_met: assert property (p_delay_met) else $error("open-field trip before delay");
  property p_trip_stop;
    @(posedge aclk) disable iff (!aresetn)
      ctrl_reg.of_en && of_qual && qual_ticks > of_delay_reg |=> rectifier_trip && excitation_stop;
  endproperty
  a_trip_stop: assert property (p_trip_stop) else $error("qualified open field did not trip");
  property p_restart;
    @(posedge aclk) disable iff (!aresetn) !of_qual && !rectifier_trip |=> !rectifier_trip;
  endproperty
  a_restart: assert property (p_restart) else $error("trip without qualifying interval");
  property p_temp;
    @(posedge aclk) disable iff (!aresetn) meas.temp > temp_lvl_reg |=> temp_alarm && status_reg[efs_pkg::ST_TEMP];
  endproperty
  a_temp: assert property (p_temp) else $error("over-temperature not flagged");
  property p_trip_dis;
    @(posedge aclk) disable iff (!aresetn) !ctrl_reg.trip_en |=> !breaker_trip && !excitation_rundown;
  endproperty
  a_trip_dis: assert property (p_trip_dis) else $error("breaker sequencing while disabled");
  property p_start;
    @(posedge aclk) disable iff (!aresetn) brk_reg == efs_pkg::BRK_IDLE && brk_start |=> excitation_rundown ##0 !breaker_trip;
  endproperty
  a_start: assert property (p_start) else $error("run-down did not start");
  property p_inv_time;
    @(posedge aclk) disable iff (!aresetn) $rose(breaker_trip) |-> $past(inv_done) && $past(brk_reg) == efs_pkg::BRK_RUNDOWN;
  endproperty
  a_inv_time: assert property (p_inv_time) else $error("breaker opened before run-down time");
  property p_sup;
    @(posedge aclk) disable iff (!aresetn)
      brk_reg == efs_pkg::BRK_WAIT && sup_done && !breaker_open_status |=> status_reg[efs_pkg::ST_BRK_FAIL];
  endproperty
  a_sup: assert property (p_sup) else $error("breaker failure event missing");
  property p_ramp;
    @(posedge aclk) disable iff (!aresetn)
      ramp_on && ctrl_reg.ramp_up && !ctrl_reg.ramp_down && ramp_sum <= {1'b0, efs_pkg::RAMP_MAX}
      |=> ramp_reg == $past(ramp_reg) + {12'h000, $past(ramp_rate_reg)};
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp step wrong");
  c_of_trip: cover property (@(posedge aclk) disable iff (!aresetn) $rose(rectifier_trip));
  c_brk_fail: cover property (@(posedge aclk) disable iff (!aresetn) brk_fail_evt);
  c_brk_open: cover property (@(posedge aclk) disable iff (!aresetn) brk_open_evt);
  c_temp: cover property (@(posedge aclk) disable iff (!aresetn) $rose(temp_alarm));
endmodule
`default_nettype wire

// [efs_supervisor_tb_top.sv]
`default_nettype none
module efs_supervisor_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, bos;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  efs_pkg::efs_meas_t meas = '0;
  logic off = 1'b0, mco = 1'b0;
  logic [15:0] odly = 16'h0032;
  logic rectifier_trip, excitation_stop, excitation_rundown, breaker_trip, temp_alarm, forced_active, irq;
  logic [19:0] fcs;
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [1:0] exp_b [$];
  logic [33:0] exp_r [$];
  logic [31:0] rv [10] = '{32'h0000_0000, {16'h0000, efs_pkg::RST_OF_HIGH}, {16'h0000, efs_pkg::RST_OF_LOW},
    {16'h0000, efs_pkg::RST_OF_DELAY}, {24'h00_0000, efs_pkg::RST_TEMP_LVL}, {16'h0000, efs_pkg::RST_INV_TIME},
    {16'h0000, efs_pkg::RST_TRIP_SUP}, {24'h00_0000, efs_pkg::RST_RAMP_RATE}, 32'h0000_0000, 32'h0000_0000};

  efs_supervisor #(.CYC_BASE(20)) dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .meas(meas), .breaker_off_cmd(off),
    .machine_circuit_open(mco), .breaker_open_status(bos), .rectifier_trip(rectifier_trip),
    .excitation_stop(excitation_stop), .excitation_rundown(excitation_rundown), .breaker_trip(breaker_trip),
    .temp_alarm(temp_alarm), .forced_control_signal(fcs), .forced_active(forced_active), .irq(irq));

  efs_breaker_model partner (.aclk(aclk), .breaker_trip(breaker_trip), .open_delay(odly),
    .breaker_open_status(bos));

  initial begin
    forever #2.5 aclk = ~aclk;
  end

  task automatic close_out();
    if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // Responses are matched in order against what the drivers noted
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
    if (bvalid === 1'b1 && bready) chk("bresp", exp_b.size() ? exp_b.pop_front() : 2'bxx, bresp);
    if (rvalid === 1'b1 && rready) chk("rdata", exp_r.size() ? exp_r.pop_front() : 'x, {rresp, rdata});
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
    bit aw, w;
    aw = 0;
    w = 0;
    exp_b.push_back(r);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && awready === 1'b1) begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1) begin
        w = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
    exp_r.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
  endtask

  function automatic logic pick(input int id);
    case (id)
      0: return rectifier_trip;
      1: return temp_alarm;
      2: return irq;
      3: return breaker_trip;
      4: return excitation_rundown;
      default: return forced_active;
    endcase
  endfunction

  // Latency of a rising output must fall inside the allowed window
  task automatic wait_for(input int id, input int lo, input int hi);
    int n;
    n = 0;
    while (pick(id) !== 1'b1 && n <= hi) begin
      @(posedge aclk);
      n++;
    end
    chk("latency", 34'd1, 34'(n >= lo && n <= hi));
  endtask

  initial begin
    void'($urandom(32'h534737ae));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 10; i++) rd(8'(4 * i), rv[i]);
    rd(8'h30, 32'h0000_0000, 2'b10);
    wr(8'h28, 32'h0000_00ff, 2'b10);
    // A control signal equal to the high threshold must not qualify; a field current equal to the low threshold does
    meas <= '{16'h0064, 16'h000a, 8'h64};
    wr(8'h00, 32'h0000_0001);
    rd(8'h28, 32'h0000_0004);
    meas <= '{16'h0065, 16'h000b, 8'h64};
    rd(8'h28, 32'h0000_0002);
    wr(8'h0c, 32'h0000_0004);
    meas <= '{16'h0065, 16'h000a, 8'($urandom_range(0, 100))};
    repeat (50) @(posedge aclk);
    meas.field_current <= 16'(11 + $urandom_range(0, 2000));
    repeat (2) @(posedge aclk);
    meas.field_current <= 16'h000a;
    wait_for(0, 60, 110);
    chk("stop", 34'd1, 34'(excitation_stop));
    rd(8'h20, 32'h0000_0001);
    wr(8'h00, 32'h0000_0000);
    meas.field_current <= 16'h0100;
    wr(8'h20, 32'h0000_0001);
    repeat (3) @(posedge aclk);
    chk("trip", 34'd0, 34'(rectifier_trip));
    // Over-temperature works with every enable off
    wr(8'h24, 32'h0000_0002);
    meas.temp <= 8'h65;
    wait_for(1, 0, 3);
    wait_for(2, 0, 3);
    wr(8'h24, 32'h0000_0000);
    repeat (2) @(posedge aclk);
    chk("irq", 34'd0, 34'(irq));
    meas.temp <= 8'($urandom_range(0, 100));
    wr(8'h20, 32'h0000_0002);
    repeat (2) @(posedge aclk);
    chk("alarm", 34'd0, 34'(temp_alarm));
    rd(8'h20, 32'h0000_0000);
    // Breaker sequence: disabled first, then a prompt and a stuck breaker
    // Two run-down ticks, so the free-running divider phase cannot hide a one-tick error
    wr(8'h14, 32'h0000_0002);
    wr(8'h18, 32'h0000_0001);
    mco <= 1'b1;
    off <= 1'b1;
    repeat (30) @(posedge aclk);
    chk("rundown", 34'd0, 34'(excitation_rundown));
    wr(8'h00, 32'h0000_0002);
    wait_for(4, 0, 3);
    wait_for(3, 402, 805);
    repeat (60) @(posedge aclk);
    rd(8'h20, 32'h0000_0008);
    off <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("brk", 34'd0, 34'(breaker_trip));
    wr(8'h20, 32'h0000_0008);
    odly <= 16'h0fff;
    off <= 1'b1;
    wait_for(3, 402, 805);
    repeat (360) @(posedge aclk);
    rd(8'h20, 32'h0000_0000);
    repeat (70) @(posedge aclk);
    rd(8'h20, 32'h0000_0004);
    off <= 1'b0;
    wr(8'h00, 32'h0000_0000);
    wr(8'h20, 32'h0000_000f);
    // Ramp up by the rate every 10 ms, then down until clamped at zero
    wr(8'h00, 32'h0000_000c);
    wait_for(5, 0, 3);
    repeat (400) @(posedge aclk);
    chk("ramp", 34'd1, 34'(fcs >= 20'd18 && fcs <= 20'd22 && !fcs[0]));
    wr(8'h00, 32'h0000_0014);
    repeat (800) @(posedge aclk);
    chk("ramp", 34'd0, 34'(fcs));
    close_out();
  end
endmodule
`default_nettype wire
